// file: logic/chip_select_decoder.sv
// How it works
// R1 - Four selects exist; this block is select zero, memory or I/O type.
// R2 - I/O decode compares ten address bits down to the single byte.
// R3 - A global bit demands I/O address bits 15..10 be zero, else ignored.
// R4 - Memory decode matches 16KB blocks anywhere in 16MB space.
// R5 - Base register gives bits 8..1 or 22..15; granularity bit 4 bit 0/14.
// R6 - Control bit 7 gives bit 9 or 23; bit 4 picks early or command timing.
// R7 - Control bit 6 enables write decode, bit 5 enables read decode.
// R8 - Ones in control low nibble or granularity bit 0 drop bits from compare.
// R9 - Cycle type bit 0 picks I/O or ROM decode; bit 4 picks ROM width 16.
// R10 - Board logic qualifies the strobe with AEN and ORs an address line.
// R11 - Software takes care with ROMs below 1MB to avoid data bus conflicts.
// R12 - Select asserts only on matching type, enabled direction, equal bits.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module chip_select_decoder
  import chipsel_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // AXI4-Lite write address and data.
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [AXI_ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response.
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read.
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [AXI_ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // Expansion bus cycle, from pins.
  input wire logic [ISA_ADDR_W-1:0] ISA_ADDR,
  input wire logic ISA_IO_CYCLE,
  input wire logic ISA_WRITE,
  input wire logic ISA_CMD_B,
  // Select and ROM width out.
  output logic PROGRAMMABLE_SELECT_ZERO_B,
  output logic ROM_WIDTH_16
);
  // ---------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------
  logic [7:0] base0;
  logic [7:0] ctrl0;
  logic [7:0] global_cfg;
  logic [7:0] cycle_type;
  logic [7:0] gran;
  logic [7:0] aw_index;
  logic aw_ok;
  logic aw_held;
  logic w_held;
  logic [7:0] w_byte;
  logic w_lane;
  localparam int unsigned PIN_W = ISA_ADDR_W + 3;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;

  select_cfg_if cfg ();

  select_match u_match (
    .cfg(cfg)
  );

  // ---------------------------------------------------------------
  // Pin synchronisers: the second stage is the only reader of the first.
  // ---------------------------------------------------------------
  wire logic [ISA_ADDR_W-1:0] addr_s;
  wire logic io_s;
  wire logic write_s;
  wire logic cmd_b_s;

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= {ISA_CMD_B, ISA_WRITE, ISA_IO_CYCLE, ISA_ADDR};
      pin_sync <= pin_meta;
    end
  end

  assign addr_s = pin_sync[ISA_ADDR_W-1:0];
  assign io_s = pin_sync[ISA_ADDR_W];
  assign write_s = pin_sync[ISA_ADDR_W+1];
  assign cmd_b_s = pin_sync[ISA_ADDR_W+2];

  // ---------------------------------------------------------------
  // Decode configuration.
  // ---------------------------------------------------------------
  wire logic early;

  assign cfg.base = {ctrl0[CTRL_BASE_HI], base0, gran[GRAN_BASE_LO]}; // R5 R6
  assign cfg.mask = {ctrl0[3:0], gran[GRAN_MASK_LO]}; // R8
  assign cfg.rom_mode = cycle_type[CYC_ROM]; // R9 R1
  assign cfg.high_zero = global_cfg[GLB_HIGH_ZERO]; // R3
  assign cfg.wr_en = ctrl0[CTRL_WR_EN]; // R7
  assign cfg.rd_en = ctrl0[CTRL_RD_EN]; // R7
  assign cfg.addr = addr_s;
  assign cfg.io_cycle = io_s;
  assign cfg.write_cycle = write_s;
  assign early = ctrl0[CTRL_EARLY];

  // Early timing drives the select from address, cycle type and direction alone, so it leads the
  // command; the board gate still qualifies it with the cycle strobe.
  wire logic next_select;

  assign next_select = cfg.match & (early | ~cmd_b_s); // R6 R12

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PROGRAMMABLE_SELECT_ZERO_B <= 1'b1;
      ROM_WIDTH_16 <= 1'b0;
    end
    else
    begin
      PROGRAMMABLE_SELECT_ZERO_B <= ~next_select; // R12
      ROM_WIDTH_16 <= cycle_type[CYC_ROM16]; // R9
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write path: address and data are taken in either order.
  // ---------------------------------------------------------------
  wire logic aw_hs;
  wire logic w_hs;
  wire logic commit;
  wire logic next_aw_held;
  wire logic next_w_held;
  wire logic next_bvalid;
  wire logic [7:0] awi;
  wire logic awi_ok;
  wire logic wr_mapped;
  wire logic wr_en;

  assign aw_hs = AWVALID & AWREADY;
  assign w_hs = WVALID & WREADY;
  assign commit = aw_held & w_held & ~BVALID;
  assign next_aw_held = (aw_held | aw_hs) & ~commit;
  assign next_w_held = (w_held | w_hs) & ~commit;
  assign next_bvalid = commit | (BVALID & ~BREADY);
  assign awi = AWADDR[9:2];
  assign awi_ok = (AWADDR[1:0] == 2'h0) & (AWADDR[AXI_ADDR_W-1:10] == '0);
  assign wr_mapped = aw_ok & ((aw_index == IDX_BASE0) | (aw_index == IDX_CTRL0)
    | (aw_index == IDX_GLOBAL) | (aw_index == IDX_CYCLE) | (aw_index == IDX_GRAN)
    | (aw_index == IDX_STATUS));
  assign wr_en = commit & aw_ok & w_lane;

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_index <= 8'h00;
      aw_ok <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      AWREADY <= ~next_aw_held & ~next_bvalid;
      WREADY <= ~next_w_held & ~next_bvalid;
      BVALID <= next_bvalid;
      if (aw_hs)
      begin
        aw_index <= awi;
        aw_ok <= awi_ok;
      end
      if (w_hs)
      begin
        w_byte <= WDATA[7:0];
        w_lane <= WSTRB[0];
      end
      if (commit)
      begin
        BRESP <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Writes without byte lane 0 are acknowledged but leave the registers alone.
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      base0 <= RST_BASE0;
      ctrl0 <= RST_CTRL0;
      global_cfg <= RST_GLOBAL;
      cycle_type <= RST_CYCLE;
      gran <= RST_GRAN;
    end
    else if (wr_en)
    begin
      if (aw_index == IDX_BASE0)
        base0 <= w_byte; // R5
      if (aw_index == IDX_CTRL0)
        ctrl0 <= w_byte; // R6
      if (aw_index == IDX_GLOBAL)
        global_cfg <= w_byte; // R3
      if (aw_index == IDX_CYCLE)
        cycle_type <= w_byte; // R9
      if (aw_index == IDX_GRAN)
        gran <= w_byte; // R8
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path.
  // ---------------------------------------------------------------
  wire logic ar_hs;
  wire logic next_rvalid;
  wire logic [7:0] ari;
  wire logic ari_ok;
  wire logic [7:0] status;
  wire logic [7:0] rd_byte;
  wire logic rd_hit;

  assign ar_hs = ARVALID & ARREADY;
  assign next_rvalid = ar_hs | (RVALID & ~RREADY);
  assign ari = ARADDR[9:2];
  assign ari_ok = (ARADDR[1:0] == 2'h0) & (ARADDR[AXI_ADDR_W-1:10] == '0);
  assign status = {6'h00, cycle_type[CYC_ROM], ~PROGRAMMABLE_SELECT_ZERO_B};
  assign rd_hit = ari_ok & ((ari == IDX_BASE0) | (ari == IDX_CTRL0)
    | (ari == IDX_GLOBAL) | (ari == IDX_CYCLE) | (ari == IDX_GRAN) | (ari == IDX_STATUS));
  assign rd_byte = ~ari_ok ? 8'h00
    : (ari == IDX_BASE0) ? base0
    : (ari == IDX_CTRL0) ? ctrl0
    : (ari == IDX_GLOBAL) ? global_cfg
    : (ari == IDX_CYCLE) ? cycle_type
    : (ari == IDX_GRAN) ? gran
    : (ari == IDX_STATUS) ? status
    : 8'h00;

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end
    else
    begin
      ARREADY <= ~next_rvalid;
      RVALID <= next_rvalid;
      if (ar_hs)
      begin
        RDATA <= {24'h00_0000, rd_byte};
        RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  sel_cycle_type_a: assert property ( // R1
    @(posedge CLK_SYS) disable iff (!RST_B)
    !PROGRAMMABLE_SELECT_ZERO_B |-> $past(cycle_type[CYC_ROM]) != $past(io_s))
    else $error("Select asserted on a cycle of the wrong type.");

  io_ten_bits_a: assert property ( // R2
    @(posedge CLK_SYS) disable iff (!RST_B)
    !PROGRAMMABLE_SELECT_ZERO_B && !$past(cycle_type[CYC_ROM])
    |-> (($past(addr_s[9:0]) ^ $past(cfg.base)) & ~{5'h00, $past(cfg.mask)}) == 10'h000)
    else $error("I/O select with an unmasked address bit off base.");

  io_high_zero_a: assert property ( // R3
    @(posedge CLK_SYS) disable iff (!RST_B)
    !PROGRAMMABLE_SELECT_ZERO_B && $past(global_cfg[GLB_HIGH_ZERO] && io_s)
    |-> $past(addr_s[15:10]) == 6'h00)
    else $error("I/O select with nonzero upper address bits.");

  mem_block_a: assert property ( // R4
    @(posedge CLK_SYS) disable iff (!RST_B)
    !PROGRAMMABLE_SELECT_ZERO_B && $past(cycle_type[CYC_ROM])
    |-> (($past(addr_s[23:14]) ^ $past(cfg.base)) & ~{5'h00, $past(cfg.mask)}) == 10'h000)
    else $error("Memory select outside the programmed block.");

  cmd_timing_a: assert property ( // R6
    @(posedge CLK_SYS) disable iff (!RST_B)
    $fell(PROGRAMMABLE_SELECT_ZERO_B) && !$past(ctrl0[CTRL_EARLY]) |-> !$past(cmd_b_s))
    else $error("Command timed select asserted without the command.");

  write_enable_a: assert property ( // R7
    @(posedge CLK_SYS) disable iff (!RST_B)
    !PROGRAMMABLE_SELECT_ZERO_B && $past(write_s) |-> $past(ctrl0[CTRL_WR_EN]))
    else $error("Write cycle selected with write decode disabled.");

  read_enable_a: assert property ( // R7
    @(posedge CLK_SYS) disable iff (!RST_B)
    !PROGRAMMABLE_SELECT_ZERO_B && !$past(write_s) |-> $past(ctrl0[CTRL_RD_EN]))
    else $error("Read cycle selected with read decode disabled.");

  rom_width_a: assert property ( // R9
    @(posedge CLK_SYS) disable iff (!RST_B)
    wr_en && aw_index == IDX_CYCLE |-> ##2 ROM_WIDTH_16 == $past(w_byte[CYC_ROM16], 2))
    else $error("ROM width output did not follow the cycle type register.");

  match_select_a: assert property ( // R12
    @(posedge CLK_SYS) disable iff (!RST_B)
    cfg.match && early ##1 cfg.match && early |-> !PROGRAMMABLE_SELECT_ZERO_B)
    else $error("Early select missing on a matching cycle.");

  write_answer_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_B)
    commit |=> BVALID && !AWREADY && !WREADY)
    else $error("Write response did not follow the commit.");
endmodule

// file: logic/chipsel_pkg.sv
package chipsel_pkg;
  // ---------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ---------------------------------------------------------------
  localparam int unsigned AXI_ADDR_W = 12;
  localparam logic [7:0] IDX_BASE0 = 8'h4a;
  localparam logic [7:0] IDX_CTRL0 = 8'h4b;
  localparam logic [7:0] IDX_GLOBAL = 8'ha7;
  localparam logic [7:0] IDX_CYCLE = 8'hb3;
  localparam logic [7:0] IDX_GRAN = 8'hbf;
  localparam logic [7:0] IDX_STATUS = 8'hc0;
  // ---------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BASE0 = 8'h00;
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_GLOBAL = 8'h00;
  localparam logic [7:0] RST_CYCLE = 8'h00;
  localparam logic [7:0] RST_GRAN = 8'h0f;
  // ---------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_BASE_HI = 7;
  localparam int unsigned CTRL_WR_EN = 6;
  localparam int unsigned CTRL_RD_EN = 5;
  localparam int unsigned CTRL_EARLY = 4;
  localparam int unsigned GRAN_BASE_LO = 4;
  localparam int unsigned GRAN_MASK_LO = 0;
  localparam int unsigned CYC_ROM16 = 4;
  localparam int unsigned CYC_ROM = 0;
  localparam int unsigned GLB_HIGH_ZERO = 7;
  localparam int unsigned STAT_SELECT = 0;
  localparam int unsigned STAT_ROM = 1;
  // ---------------------------------------------------------------
  // Decode geometry and bus answers.
  // ---------------------------------------------------------------
  localparam int unsigned ISA_ADDR_W = 24;
  localparam int unsigned FIELD_W = 10;
  localparam int unsigned MASK_W = 5;
  localparam int unsigned IO_FIELD_LSB = 0;
  localparam int unsigned MEM_FIELD_LSB = 14;
  localparam int unsigned IO_HIGH_LSB = 10;
  localparam int unsigned IO_HIGH_MSB = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: logic/select_cfg_if.sv
interface select_cfg_if;
  import chipsel_pkg::*;
  logic [FIELD_W-1:0] base;
  logic [MASK_W-1:0] mask;
  logic rom_mode;
  logic high_zero;
  logic rd_en;
  logic wr_en;
  logic [ISA_ADDR_W-1:0] addr;
  logic io_cycle;
  logic write_cycle;
  logic match;
  modport ctl (output base, mask, rom_mode, high_zero, rd_en, wr_en, addr, io_cycle,
    write_cycle, input match);
  modport dec (input base, mask, rom_mode, high_zero, rd_en, wr_en, addr, io_cycle,
    write_cycle, output match);
endinterface

// file: logic/select_match.sv
module select_match
  import chipsel_pkg::*;
(
  // Configuration and cycle in, match out.
  select_cfg_if.dec cfg
);
  // ---------------------------------------------------------------
  // Compared field: A[9:0] for I/O, A[23:14] for memory.
  // ---------------------------------------------------------------
  wire logic [FIELD_W-1:0] field;
  wire logic [FIELD_W-1:0] ignore;
  wire logic [FIELD_W-1:0] differ;
  wire logic high_ok;
  wire logic type_ok;
  wire logic dir_ok;

  assign field = cfg.rom_mode ? cfg.addr[MEM_FIELD_LSB +: FIELD_W] // R4
    : cfg.addr[IO_FIELD_LSB +: FIELD_W]; // R2
  assign ignore = {{(FIELD_W-MASK_W){1'b0}}, cfg.mask}; // R8
  assign differ = (field ^ cfg.base) & ~ignore; // R5
  // Bits 15 to 10 only count in I/O mode and only when software asks for it.
  assign high_ok = cfg.rom_mode | ~cfg.high_zero
    | (cfg.addr[IO_HIGH_MSB:IO_HIGH_LSB] == '0); // R3
  assign type_ok = cfg.rom_mode ? ~cfg.io_cycle : cfg.io_cycle; // R9
  assign dir_ok = cfg.write_cycle ? cfg.wr_en : cfg.rd_en; // R7
  assign cfg.match = type_ok & dir_ok & high_ok & (differ == '0); // R12
endmodule

// file: verif/isa_bus_model.sv
module isa_bus_model
  import chipsel_pkg::*;
(
  // Bus clock.
  input wire logic clk,
  // Cycle pins toward the decoder.
  output logic [ISA_ADDR_W-1:0] addr,
  output logic io_cycle,
  output logic write_cycle,
  output logic cmd_b
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    addr = '0;
    io_cycle = 1'b0;
    write_cycle = 1'b0;
    cmd_b = 1'b1;
  end

  task automatic start(input logic [ISA_ADDR_W-1:0] a, input logic io, input logic wr,
    input logic cmd);
    @(posedge clk);
    addr <= a;
    io_cycle <= io;
    write_cycle <= wr;
    cmd_b <= cmd;
  endtask

  // Released address lines show the inverse of their last value; command goes high, type and direction hold.
  task automatic finish_cycle();
    @(posedge clk);
    cmd_b <= 1'b1;
    addr <= ~addr;
  endtask
endmodule

// file: verif/test_programmable_chip_select_decoder.sv
module test_programmable_chip_select_decoder
  import chipsel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, sel_b, rom16;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [ISA_ADDR_W-1:0] isa_addr, a;
  logic isa_io, isa_wr, isa_cmd_b, io, e;
  logic [9:0] b10, m10;
  int error_cnt, n_compared, seed;
  logic [7:0] cfg [5];
  logic [7:0] idx [6] = '{IDX_BASE0, IDX_CTRL0, IDX_GLOBAL, IDX_CYCLE, IDX_GRAN, IDX_STATUS};
  logic [7:0] rst_v [6] = '{RST_BASE0, RST_CTRL0, RST_GLOBAL, RST_CYCLE, RST_GRAN, 8'h00};

  chip_select_decoder dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b), .AWVALID(awvalid),
    .AWREADY(awready), .AWADDR(awaddr), .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready),
    .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
    .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0), .RVALID(rvalid),
    .RREADY(rready), .RDATA(rdata), .RRESP(rresp), .ISA_ADDR(isa_addr), .ISA_IO_CYCLE(isa_io),
    .ISA_WRITE(isa_wr), .ISA_CMD_B(isa_cmd_b), .PROGRAMMABLE_SELECT_ZERO_B(sel_b),
    .ROM_WIDTH_16(rom16));

  isa_bus_model isa_u (.clk(clk_sys), .addr(isa_addr), .io_cycle(isa_io),
    .write_cycle(isa_wr), .cmd_b(isa_cmd_b));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Reporting.
  // ---------------------------------------------------------------
  task automatic fail(input string m);
    error_cnt++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e, input string m);
    n_compared++;
    if (g !== e) fail(m);
  endtask

  task automatic chk_data(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) fail(m);
  endtask

  task automatic chk_pin(input logic g, input logic e, input string m);
    n_compared++;
    if (g !== e) fail(m);
  endtask

  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Register bus master.
  // ---------------------------------------------------------------
  function automatic logic [AXI_ADDR_W-1:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic axi_wr(input logic [11:0] ad, input logic [31:0] dt, input logic [3:0] s,
    output logic [1:0] rs);
    int n;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    rs = 2'bxx;
    @(posedge clk_sys);
    awaddr <= ad;
    wdata <= dt;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk_sys);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 100) fail("write never answered");
  endtask

  task automatic axi_rd(input logic [11:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    int n;
    logic ar_ok;
    ar_ok = 1'b0;
    rs = 2'bxx;
    @(posedge clk_sys);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk_sys);
      if (!ar_ok && arready === 1'b1)
      begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1)
      begin
        dt = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 100) fail("read never answered");
  endtask

  // Writes the five configuration registers from the cfg array.
  task automatic wr_cfg();
    logic [1:0] rs;
    for (int i = 0; i < 5; i++)
    begin
      axi_wr(ba(idx[i]), {24'h0, cfg[i]}, 4'h1, rs);
      chk_resp(rs, RESP_OKAY, "write response");
    end
  endtask

  // ---------------------------------------------------------------
  // Expected select, worked out from the configuration and the cycle pins alone.
  // ---------------------------------------------------------------
  function automatic logic exp_sel(input logic [ISA_ADDR_W-1:0] ad, input logic i,
    input logic w, input logic c_b);
    logic [9:0] f;
    logic rom, hi_ok;
    rom = cfg[3][0];
    f = rom ? ad[23:14] : ad[9:0];
    hi_ok = rom || !cfg[2][7] || ad[15:10] == 6'h00;
    return (rom ? !i : i) && (w ? cfg[1][6] : cfg[1][5]) && hi_ok && (cfg[1][4] || !c_b) &&
      (((f ^ {cfg[1][7], cfg[0], cfg[4][4]}) & ~{5'h00, cfg[1][3:0], cfg[4][0]}) == 10'h000);
  endfunction

  initial
  begin
    #100us;
    fail("run did not finish in time");
    conclude();
  end

  initial
  begin
    error_cnt = 0;
    n_compared = 0;
    seed = 32'ha7aa;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h0;
    rst_b = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 6; i++)
    begin
      axi_rd(ba(idx[i]), d, r);
      chk_data(d, {24'h0, rst_v[i]}, "reset value");
    end
    axi_rd(12'h040, d, r);
    chk_resp(r, RESP_SLVERR, "unmapped read response");
    chk_data(d, 32'h0, "unmapped read data");
    axi_wr(ba(IDX_BASE0) + 12'h001, 32'hff, 4'h1, r);
    chk_resp(r, RESP_SLVERR, "misaligned write response");
    axi_wr(ba(IDX_BASE0), 32'h5a, 4'h0, r);
    chk_resp(r, RESP_OKAY, "write without strobe response");
    axi_rd(ba(IDX_BASE0), d, r);
    chk_data(d, 32'h0, "write without strobe stored");
    // Command timed I/O select at 0x2a5 with the upper bits required zero.
    cfg = '{8'h52, 8'he0, 8'h80, 8'h00, 8'h10};
    wr_cfg();
    isa_u.start(24'h0002a5, 1'b1, 1'b0, 1'b1);
    repeat (4) @(posedge clk_sys);
    chk_pin(sel_b, 1'b1, "select without command");
    isa_u.start(24'h0002a5, 1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge clk_sys);
    chk_pin(sel_b, 1'b0, "select with command");
    axi_rd(ba(IDX_STATUS), d, r);
    chk_data(d, 32'h1, "status select bit");
    isa_u.start(24'h0006a5, 1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge clk_sys);
    chk_pin(sel_b, 1'b1, "select with upper bit set");
    isa_u.finish_cycle();
    // Random configurations; half of the cycles are built to hit the block.
    for (int t = 0; t < 80; t++)
    begin
      for (int i = 0; i < 5; i++)
        cfg[i] = 8'($random(seed));
      // Memory blocks are kept at or above 8MB, clear of the ROMs below 1MB.
      if (cfg[3][0]) cfg[1][7] = 1'b1;
      wr_cfg();
      axi_rd(ba(IDX_CTRL0), d, r);
      chk_data(d, {24'h0, cfg[1]}, "control readback");
      a = 24'($random(seed));
      io = 1'($random(seed));
      if (t[0])
      begin
        b10 = {cfg[1][7], cfg[0], cfg[4][4]};
        m10 = 10'($random(seed)) & {5'h00, cfg[1][3:0], cfg[4][0]};
        io = !cfg[3][0];
        if (cfg[3][0]) a[23:14] = b10 ^ m10;
        else a[9:0] = b10 ^ m10;
        if (t[1] && !cfg[3][0]) a[15:10] = 6'h00;
      end
      isa_u.start(a, io, 1'($random(seed)), 1'($random(seed)));
      repeat (4) @(posedge clk_sys);
      e = exp_sel(a, io, isa_wr, isa_cmd_b);
      chk_pin(sel_b, !e, "select level");
      chk_pin(rom16, cfg[3][4], "ROM width");
      axi_rd(ba(IDX_STATUS), d, r);
      chk_data(d, {30'h0, cfg[3][0], e}, "status");
      isa_u.finish_cycle();
    end
    conclude();
  end
endmodule
